// ### design/abp_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
module abp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic     clk,
    input  wire logic     rst,
    abp_stream_if.snk     in_s,
    abp_stream_if.src     out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW:0]   wr_ptr;
    logic [AW:0]   rd_ptr;
    logic          full;
    logic          empty;
    logic          push;
    logic          pop;

    // Extra pointer bit separates full from empty without a counter
    assign empty = (wr_ptr == rd_ptr);
    assign full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign push  = in_s.valid && !full;
    assign pop   = out_s.ready && !empty;

    assign in_s.ready  = !full;
    assign out_s.valid = !empty;
    assign out_s.data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_s.data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

// ### design/abp_port.sv
// Master end of the asynchronous multiplexed backplane bus, as seen from the CPU
//
// Function
// - Data-out strobe only while write data driven, deskewed
// - Data-in under address strobe marks read transfer
// - Data-in without address strobe is interrupt acknowledge
// - Address strobe after address placed, held until end
// - Write/byte asserted at address strobe for writes
// - Write/byte again during data-out for byte writes
// - Level-4 request with status bit7 clear gets acknowledged
// - I/O-page select with 13-bit page offset
// - DMA grant chained only to a requesting option
// - Bus initialize returns all units to state zero
// - Shared lines carry address first, then data
`include "abp_defines.svh"

module abp_port #(
    parameter int DESKEW_CYC = `ABP_DESKEW_CYC,
    parameter int FIFO_DEPTH = `ABP_FIFO_DEPTH
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    // User command side
    input  wire logic                      cmd_valid,
    output logic                           cmd_ready,
    input  wire logic                      cmd_write,
    input  wire logic                      cmd_byte,
    input  wire logic                      cmd_io_page,
    input  wire logic [`ABP_ADDR_W-1:0]    cmd_addr,
    input  wire logic [`ABP_DATA_W-1:0]    cmd_data,
    input  wire logic                      psw_bit7,
    output logic                           rsp_valid,
    output logic                           rsp_vector,
    output logic [`ABP_DATA_W-1:0]         rsp_data,
    output logic                           dma_active,
    // Backplane side
    input  wire logic [`ABP_ADDR_W-1:0]    muxed_addr_data_in,
    output logic [`ABP_ADDR_W-1:0]         muxed_addr_data_out,
    output logic                           muxed_addr_data_oe_n,
    output logic                           address_strobe_n,
    output logic                           data_in_strobe_n,
    output logic                           data_out_strobe_n,
    output logic                           write_byte_qual_n,
    output logic                           io_page_select_n,
    input  wire logic                      slave_reply_n,
    input  wire logic                      intr_req_level4_n,
    output logic                           intr_ack_chain_out_n,
    input  wire logic                      dma_request_n,
    output logic                           dma_grant_chain_out_n,
    input  wire logic                      select_acknowledge_n,
    output logic                           bus_initialize_n
);
    localparam logic [`ABP_DLY_W-1:0] DSK_LOAD = `ABP_DLY_W'(DESKEW_CYC - 1);

    // ****************************************************************
    // Command buffer
    // ****************************************************************
    abp_stream_if #(.W($bits(abp_pkg::abp_cmd_t))) in_s ();
    abp_stream_if #(.W($bits(abp_pkg::abp_cmd_t))) out_s ();

    assign in_s.valid = cmd_valid;
    assign in_s.data  = {cmd_write, cmd_byte, cmd_io_page, cmd_addr, cmd_data};
    assign cmd_ready  = in_s.ready;

    abp_fifo #(
        .W     ($bits(abp_pkg::abp_cmd_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk   (clk),
        .rst   (rst),
        .in_s  (in_s),
        .out_s (out_s)
    );

    // ****************************************************************
    // Bus engine
    // ****************************************************************
    abp_pkg::abp_state_t        state;
    abp_pkg::abp_state_t        next_state;
    abp_pkg::abp_cmd_t          cur;
    logic [`ABP_DLY_W-1:0]      dly;
    logic                       in_ack;
    logic                       take_ack;
    logic                       take_cmd;
    logic                       strobe_phase;

    assign take_ack = !intr_req_level4_n && !psw_bit7;
    assign take_cmd = (state == abp_pkg::ST_IDLE) && (next_state == abp_pkg::ST_ADDR);
    assign out_s.ready = take_cmd;
    assign strobe_phase = (state == abp_pkg::ST_STROBE) || (state == abp_pkg::ST_RDSKEW);

    always_comb begin
        next_state = state;
        unique case (state)
            abp_pkg::ST_IDLE: begin
                // Interrupts first, then DMA, then queued CPU cycles
                if (take_ack) begin
                    next_state = abp_pkg::ST_STROBE;
                end else if (!dma_request_n) begin
                    next_state = abp_pkg::ST_GRANT;
                end else if (out_s.valid) begin
                    next_state = abp_pkg::ST_ADDR;
                end
            end
            abp_pkg::ST_ADDR: begin
                if (dly == '0) begin
                    next_state = abp_pkg::ST_SYNC;
                end
            end
            abp_pkg::ST_SYNC: begin
                if (dly == '0) begin
                    next_state = abp_pkg::ST_STROBE;
                end
            end
            abp_pkg::ST_STROBE: begin
                if (!slave_reply_n) begin
                    if (cur.write && !in_ack) begin
                        next_state = abp_pkg::ST_RELEASE;
                    end else begin
                        next_state = abp_pkg::ST_RDSKEW;
                    end
                end
            end
            abp_pkg::ST_RDSKEW: begin
                if (dly == '0) begin
                    next_state = abp_pkg::ST_RELEASE;
                end
            end
            abp_pkg::ST_RELEASE: begin
                if (slave_reply_n) begin
                    next_state = abp_pkg::ST_DONE;
                end
            end
            abp_pkg::ST_DONE: begin
                next_state = abp_pkg::ST_IDLE;
            end
            abp_pkg::ST_GRANT: begin
                if (!select_acknowledge_n) begin
                    next_state = abp_pkg::ST_DMA;
                end else if (dma_request_n) begin
                    next_state = abp_pkg::ST_IDLE;
                end
            end
            abp_pkg::ST_DMA: begin
                if (select_acknowledge_n) begin
                    next_state = abp_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= abp_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Every phase change restarts the deskew wait
    always_ff @(posedge clk) begin
        if (rst) begin
            dly <= '0;
        end else if (state != next_state) begin
            dly <= DSK_LOAD;
        end else if (dly != '0) begin
            dly <= dly - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
        end else if (take_cmd) begin
            cur <= out_s.data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            in_ack <= 1'b0;
        end else if (state == abp_pkg::ST_IDLE) begin
            in_ack <= take_ack;
        end
    end

    // Read data and vectors are sampled only after the deskew wait
    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_valid  <= 1'b0;
            rsp_vector <= 1'b0;
            rsp_data   <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (state == abp_pkg::ST_RDSKEW && dly == '0) begin
                rsp_valid  <= 1'b1;
                rsp_vector <= in_ack;
                rsp_data   <= muxed_addr_data_in[`ABP_DATA_W-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_initialize_n <= 1'b0;
        end else begin
            bus_initialize_n <= 1'b1;
        end
    end

    // ****************************************************************
    // Pin decode
    // ****************************************************************
    always_comb begin
        muxed_addr_data_oe_n = 1'b1;
        muxed_addr_data_out  = '0;
        if (state == abp_pkg::ST_ADDR) begin
            muxed_addr_data_oe_n = 1'b0;
            muxed_addr_data_out  = cur.addr;
        end else if (cur.write && (state == abp_pkg::ST_SYNC || state == abp_pkg::ST_STROBE)
                     && !in_ack) begin
            muxed_addr_data_oe_n = 1'b0;
            muxed_addr_data_out  = {{(`ABP_ADDR_W-`ABP_DATA_W){1'b0}}, cur.data};
        end
    end

    // Address strobe spans SYNC through RELEASE, not the address time; never raised in an acknowledge
    assign address_strobe_n = in_ack ||
        !(state == abp_pkg::ST_SYNC || strobe_phase || state == abp_pkg::ST_RELEASE);

    assign data_in_strobe_n  = !(strobe_phase && (!cur.write || in_ack));
    assign data_out_strobe_n = !(state == abp_pkg::ST_STROBE && cur.write && !in_ack);
    assign intr_ack_chain_out_n = !(strobe_phase && in_ack);

    // Write flag during address time; byte flag again during the data-out strobe
    assign write_byte_qual_n =
        !((state == abp_pkg::ST_ADDR && cur.write) ||
          (state == abp_pkg::ST_STROBE && cur.write && !in_ack
           && cur.byte_sel == `ABP_BYTE_CMD));

    assign io_page_select_n = !(cur.io_page && !in_ack && state != abp_pkg::ST_IDLE
        && state != abp_pkg::ST_DONE && state != abp_pkg::ST_GRANT
        && state != abp_pkg::ST_DMA);

    assign dma_grant_chain_out_n = !(state == abp_pkg::ST_GRANT);
    assign dma_active            = (state == abp_pkg::ST_DMA);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_dout_with_data;
        !data_out_strobe_n |-> !muxed_addr_data_oe_n
            && muxed_addr_data_out[`ABP_DATA_W-1:0] == cur.data;
    endproperty
    a_dout_with_data: assert property (p_dout_with_data)
        else $error("data-out strobe without write data");

    property p_dout_deskew;
        $fell(data_out_strobe_n) |-> $past(!muxed_addr_data_oe_n, 2)
            && $past(state) == abp_pkg::ST_SYNC;
    endproperty
    a_dout_deskew: assert property (p_dout_deskew)
        else $error("data-out strobe not deskewed after data");

    property p_din_kind;
        !data_in_strobe_n |-> (!address_strobe_n ^ !intr_ack_chain_out_n);
    endproperty
    a_din_kind: assert property (p_din_kind)
        else $error("data-in neither read nor acknowledge");

    property p_iak_cause;
        $fell(intr_ack_chain_out_n) |-> !data_in_strobe_n && address_strobe_n
            && $past(!intr_req_level4_n) && $past(!psw_bit7);
    endproperty
    a_iak_cause: assert property (p_iak_cause)
        else $error("acknowledge without enabled level-4 request");

    property p_sync_after_addr;
        $fell(address_strobe_n) |-> $past(!muxed_addr_data_oe_n)
            && $past(muxed_addr_data_out) == cur.addr;
    endproperty
    a_sync_after_addr: assert property (p_sync_after_addr)
        else $error("address strobe before address driven");

    property p_wtbt_lead;
        $fell(address_strobe_n) |-> $past(write_byte_qual_n) == !cur.write;
    endproperty
    a_wtbt_lead: assert property (p_wtbt_lead)
        else $error("write/byte wrong at address strobe");

    property p_wtbt_byte;
        !data_out_strobe_n |-> write_byte_qual_n == (cur.byte_sel != `ABP_BYTE_CMD);
    endproperty
    a_wtbt_byte: assert property (p_wtbt_byte)
        else $error("write/byte wrong during data-out");

    property p_strobe_interlock;
        ($rose(data_in_strobe_n) || $rose(data_out_strobe_n)) |-> $past(!slave_reply_n);
    endproperty
    a_strobe_interlock: assert property (p_strobe_interlock)
        else $error("data strobe dropped without reply");

    property p_sync_end;
        $rose(address_strobe_n) && !in_ack |-> $past(slave_reply_n)
            && $past(data_in_strobe_n) && $past(data_out_strobe_n);
    endproperty
    a_sync_end: assert property (p_sync_end)
        else $error("address strobe dropped early");

    property p_grant_cause;
        $fell(dma_grant_chain_out_n) |-> $past(!dma_request_n);
    endproperty
    a_grant_cause: assert property (p_grant_cause)
        else $error("grant issued without request");

    property p_iopage_off;
        !io_page_select_n |-> !in_ack && cur.io_page;
    endproperty
    a_iopage_off: assert property (p_iopage_off)
        else $error("I/O-page select outside its cycle");

    property p_init;
        @(posedge clk) disable iff (1'b0)
        rst |=> !bus_initialize_n && address_strobe_n && data_in_strobe_n
            && data_out_strobe_n && dma_grant_chain_out_n && !rsp_valid;
    endproperty
    a_init: assert property (p_init)
        else $error("bus not held in initial state during reset");
endmodule

// ### include/abp_defines.svh
// Constants of the backplane bus port: widths, depths and handshake timing
`ifndef ABP_DEFINES_SVH
`define ABP_DEFINES_SVH

`define ABP_ADDR_W          18
`define ABP_DATA_W          16
`define ABP_IOPAGE_W        13
`define ABP_FIFO_DEPTH      16
`define ABP_CLK_PERIOD_NS   4
`define ABP_DESKEW_NS       100
`define ABP_DESKEW_CYC      ((`ABP_DESKEW_NS + `ABP_CLK_PERIOD_NS - 1) / `ABP_CLK_PERIOD_NS)
`define ABP_DLY_W           8
`define ABP_WORD_CMD        1'b0
`define ABP_BYTE_CMD        1'b1

`endif

// ### include/abp_pkg.sv
// Types shared by the backplane bus port and its command buffer
`include "abp_defines.svh"

package abp_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_SYNC,
        ST_STROBE,
        ST_RDSKEW,
        ST_RELEASE,
        ST_DONE,
        ST_GRANT,
        ST_DMA
    } abp_state_t;

    typedef struct packed {
        logic                    write;
        logic                    byte_sel;
        logic                    io_page;
        logic [`ABP_ADDR_W-1:0]  addr;
        logic [`ABP_DATA_W-1:0]  data;
    } abp_cmd_t;

endpackage

// ### include/abp_stream_if.sv
// Valid/ready word stream between the command buffer and the bus engine
interface abp_stream_if #(
    parameter int W = 8
);
    logic          valid;
    logic          ready;
    logic [W-1:0]  data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ### test/abp_slave_model.sv
// Option-module model that answers the backplane bus port from the far side
module abp_slave_model #(
    parameter logic [15:0] VECTOR = 16'h00C4
) (
    input  wire logic        clk,
    input  wire logic [17:0] muxed_addr_data_out,
    input  wire logic        muxed_addr_data_oe_n,
    input  wire logic        address_strobe_n,
    input  wire logic        data_in_strobe_n,
    input  wire logic        data_out_strobe_n,
    input  wire logic        write_byte_qual_n,
    input  wire logic        io_page_select_n,
    input  wire logic        intr_ack_chain_out_n,
    input  wire logic        dma_grant_chain_out_n,
    input  wire logic        bus_initialize_n,
    input  wire logic        want_irq,
    input  wire logic        want_dma,
    input  wire logic [7:0]  lat,
    output logic [17:0]      muxed_addr_data_in,
    output logic             slave_reply_n,
    output logic             intr_req_level4_n,
    output logic             dma_request_n,
    output logic             select_acknowledge_n
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Request lines and bus value
    // ****************************************
    logic [15:0] mem [16];
    logic [17:0] addr;
    logic [17:0] last;
    logic        io;
    logic        drive;
    logic        irq_done;
    logic        acked;
    logic        strobe;
    logic [7:0]  cnt;
    logic        wr;

    assign intr_req_level4_n = !(want_irq && !irq_done);
    assign dma_request_n     = !want_dma;
    // Acknowledge is taken only while this option requests or is already replying
    assign acked  = !data_in_strobe_n && address_strobe_n && !intr_ack_chain_out_n
                    && (!intr_req_level4_n || !slave_reply_n);
    assign strobe = !data_out_strobe_n || (!data_in_strobe_n && !address_strobe_n)
                    || acked;
    assign wr     = !data_out_strobe_n;

    // Released lines show a moving pattern so stale data can never pass
    always_comb begin
        if (!muxed_addr_data_oe_n)
            muxed_addr_data_in = muxed_addr_data_out;
        else if (drive)
            muxed_addr_data_in = {2'b00, acked ? VECTOR : mem[addr[4:1]]};
        else
            muxed_addr_data_in = ~last;
    end

    // ****************************************
    // Reply handshake and grant chain
    // ****************************************
    always @(posedge clk) begin
        last <= muxed_addr_data_in;
        if (!bus_initialize_n) begin
            slave_reply_n        <= 1'b1;
            select_acknowledge_n <= 1'b1;
            drive                <= 1'b0;
            irq_done             <= 1'b0;
            cnt                  <= 8'h00;
        end else begin
            if (address_strobe_n && !muxed_addr_data_oe_n) begin
                addr <= muxed_addr_data_out;
                io   <= !io_page_select_n;
            end
            cnt <= strobe ? cnt + 8'h01 : 8'h00;
            if (strobe && cnt >= lat) begin
                slave_reply_n <= 1'b0;
                drive         <= !data_in_strobe_n;
                irq_done      <= irq_done || acked;
                if (wr && write_byte_qual_n)
                    mem[addr[4:1]] <= muxed_addr_data_out[15:0];
                else if (wr && addr[0])
                    mem[addr[4:1]][15:8] <= muxed_addr_data_out[15:8];
                else if (wr)
                    mem[addr[4:1]][7:0] <= muxed_addr_data_out[7:0];
            end else if (!strobe) begin
                slave_reply_n <= 1'b1;
                drive         <= 1'b0;
            end
            if (!want_irq)
                irq_done <= 1'b0;
            // Holds the bus without transfers until want_dma falls
            select_acknowledge_n <= !(want_dma && (!dma_grant_chain_out_n
                                    || !select_acknowledge_n));
        end
    end
endmodule

// ### test/test_async_backplane_bus_port.sv
// Self-checking bench of the backplane bus port against an option model
module test_async_backplane_bus_port;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Signals and instances
    // ****************************************
    localparam logic [15:0] VEC = 16'h00C4;   // Arbitrary vector value
    logic        clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_write = 1'b0, cmd_byte = 1'b0;
    logic        cmd_io_page = 1'b0, psw_bit7 = 1'b1, want_irq = 1'b0, want_dma = 1'b0;
    logic [17:0] cmd_addr = 18'h00000;
    logic [15:0] cmd_data = 16'h0000;
    logic [7:0]  lat = 8'h03;
    logic        cmd_ready, rsp_valid, rsp_vector, dma_active, muxed_addr_data_oe_n;
    logic        address_strobe_n, data_in_strobe_n, data_out_strobe_n, write_byte_qual_n;
    logic        io_page_select_n, intr_ack_chain_out_n, dma_grant_chain_out_n, bus_initialize_n;
    logic        slave_reply_n, intr_req_level4_n, dma_request_n, select_acknowledge_n;
    logic [15:0] rsp_data;
    logic [17:0] muxed_addr_data_out, muxed_addr_data_in;
    logic        wt_sync, wt_dout, wt_pre, ack_seen, gnt_seen, prev_as;
    int          err_count = 0;
    int          num_checks = 0;

    abp_port #(.DESKEW_CYC(2)) i_abp_port (.clk, .rst, .cmd_valid, .cmd_ready, .cmd_write,
        .cmd_byte, .cmd_io_page, .cmd_addr, .cmd_data, .psw_bit7, .rsp_valid, .rsp_vector,
        .rsp_data, .dma_active, .muxed_addr_data_in, .muxed_addr_data_out, .muxed_addr_data_oe_n,
        .address_strobe_n, .data_in_strobe_n, .data_out_strobe_n, .write_byte_qual_n,
        .io_page_select_n, .slave_reply_n, .intr_req_level4_n, .intr_ack_chain_out_n,
        .dma_request_n, .dma_grant_chain_out_n, .select_acknowledge_n, .bus_initialize_n);

    abp_slave_model #(.VECTOR(VEC)) i_abp_slave_model (.clk, .muxed_addr_data_out,
        .muxed_addr_data_oe_n, .address_strobe_n, .data_in_strobe_n, .data_out_strobe_n,
        .write_byte_qual_n, .io_page_select_n, .intr_ack_chain_out_n, .dma_grant_chain_out_n,
        .bus_initialize_n, .want_irq, .want_dma, .lat, .muxed_addr_data_in, .slave_reply_n,
        .intr_req_level4_n, .dma_request_n, .select_acknowledge_n);

    always #2 clk = ~clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic waitfor(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 3000) begin
            tick(1);
            n++;
        end
        check(s, v);
    endtask

    task automatic send(input logic w, b, io, input logic [17:0] a, input logic [15:0] d);
        logic ok;
        ok = 1'b0;
        {cmd_valid, cmd_write, cmd_byte, cmd_io_page, cmd_addr, cmd_data} = {1'b1, w, b, io, a, d};
        while (ok !== 1'b1) begin
            @(negedge clk);
            ok = cmd_ready;
            tick(1);
        end
        cmd_valid = 1'b0;
    endtask

    task automatic wr(input logic b, io, input logic [17:0] a, input logic [15:0] d);
        send(1'b1, b, io, a, d);
        waitfor(address_strobe_n, 1'b0);
        waitfor(address_strobe_n, 1'b1);
    endtask

    task automatic rd(input logic [17:0] a, input logic [15:0] exp);
        send(1'b0, 1'b0, 1'b0, a, 16'h0000);
        waitfor(rsp_valid, 1'b1);
        check({rsp_vector, rsp_data}, {1'b0, exp});
        waitfor(address_strobe_n, 1'b1);
    endtask

    // Watches the wire every cycle where it has settled
    always @(negedge clk) begin
        if (!rst) begin
            if (!data_out_strobe_n) check(muxed_addr_data_oe_n, 1'b0);
            if (!data_in_strobe_n && address_strobe_n)
                check(intr_ack_chain_out_n, 1'b0);
            if (!data_out_strobe_n) wt_dout = write_byte_qual_n;
            if (!address_strobe_n && prev_as) wt_sync = wt_pre;
            if (!intr_ack_chain_out_n) ack_seen = 1'b1;
            if (!dma_grant_chain_out_n) gnt_seen = 1'b1;
        end
        prev_as = address_strobe_n;
        wt_pre = write_byte_qual_n;
    end

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        tick(2);
        check({bus_initialize_n, address_strobe_n, data_out_strobe_n, data_in_strobe_n,
               muxed_addr_data_oe_n, intr_ack_chain_out_n, dma_grant_chain_out_n, cmd_ready},
              18'h0007F);
        rst = 1'b0;
        tick(1);
        check(bus_initialize_n, 1'b1);
    endtask

    task automatic t_word;
        wr(1'b0, 1'b0, 18'h20006, 16'hC35A);
        check(i_abp_slave_model.addr, 18'h20006);
        check({wt_sync, wt_dout}, 18'h00001);
        rd(18'h20006, 16'hC35A);
        check(wt_sync, 1'b1);
        wr(1'b0, 1'b1, 18'h01FFE, 16'h0F0F);
        check({i_abp_slave_model.io, i_abp_slave_model.addr[12:0]}, 18'h03FFE);
    endtask

    task automatic t_byte;
        wr(1'b0, 1'b0, 18'h00004, 16'h1234);
        wr(1'b1, 1'b0, 18'h00005, 16'hAB00);
        check(wt_dout, 1'b0);
        wr(1'b1, 1'b0, 18'h00004, 16'h00CD);
        rd(18'h00004, 16'hABCD);
    endtask

    task automatic t_irq;
        ack_seen = 1'b0;
        want_irq = 1'b1;
        tick(40);
        check(ack_seen, 1'b0);
        psw_bit7 = 1'b0;
        waitfor(rsp_valid, 1'b1);
        check({rsp_vector, rsp_data}, {1'b1, VEC});
        waitfor(data_in_strobe_n, 1'b1);
        check({ack_seen, intr_ack_chain_out_n, address_strobe_n}, 18'h00007);
        want_irq = 1'b0;
        psw_bit7 = 1'b1;
        tick(4);
    endtask

    task automatic t_dma;
        gnt_seen = 1'b0;
        want_dma = 1'b1;
        waitfor(dma_active, 1'b1);
        check({gnt_seen, dma_grant_chain_out_n, address_strobe_n}, 18'h00007);
        want_dma = 1'b0;
        waitfor(dma_active, 1'b0);
    endtask

    // Slow replies let the buffer fill: 16 words queued plus one on the bus
    task automatic t_fifo;
        int   n;
        logic ok;
        n = 0;
        ok = 1'b1;
        lat = 8'd40;
        {cmd_valid, cmd_write, cmd_byte, cmd_io_page} = 4'b1100;
        while (ok && n < 20) begin
            cmd_addr = 18'(2 * n);
            cmd_data = 16'(n + 16'h0100);
            @(negedge clk);
            ok = cmd_ready;
            tick(1);
            if (ok) n++;
        end
        cmd_valid = 1'b0;
        check(18'(n), 18'd17);
        lat = 8'd1;
        tick(1);
        rd(18'h00000, 16'h0110);
        rd(18'h0001E, 16'h010F);
    endtask

    initial begin
        t_reset();
        t_word();
        t_byte();
        t_irq();
        t_dma();
        t_fifo();
        results();
    end

    initial begin
        #100000;
        err_count++;
        results();
    end
endmodule
